/* pkg/swh_pkg.sv */
/*
  Shared constants for the single-wire host controller: line timing in
  microseconds, the tick counts derived from it, frame numbering and the
  command and state encodings.
  Assumes one 100 MHz clock and a device that has just left reset in its fast mode.
*/
`default_nettype none

package swh_pkg;

  // Clock and timebase
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W = 7;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  // Line times in microseconds (plain defaults, adjust per device grade)
  localparam int unsigned RESET_HS_US = 150;
  localparam int unsigned RESET_STD_US = 480;
  localparam int unsigned DISCHARGE_US = 600;
  localparam int unsigned RECOVERY_US = 10;
  localparam int unsigned DISC_REQ_US = 1;
  localparam int unsigned DISC_SAMPLE_US = 2;
  localparam int unsigned DISC_FRAME_US = 24;
  localparam int unsigned START_HIGH_US = 150;
  localparam int unsigned BIT_US = 12;
  localparam int unsigned LOW0_US = 8;
  localparam int unsigned LOW1_US = 1;
  localparam int unsigned RD_US = 1;
  localparam int unsigned MRS_US = 2;

  // Same times as tick counts of the elapsed-time counter
  localparam int unsigned EL_W = 10;
  localparam logic [EL_W-1:0] RESET_HS_T = EL_W'(RESET_HS_US * NS_PER_US / TICK_NS);
  localparam logic [EL_W-1:0] RESET_STD_T = EL_W'(RESET_STD_US * NS_PER_US / TICK_NS);
  localparam logic [EL_W-1:0] DISCHARGE_T = EL_W'(DISCHARGE_US * NS_PER_US / TICK_NS);
  localparam logic [EL_W-1:0] RECOVERY_T = EL_W'(RECOVERY_US * NS_PER_US / TICK_NS);
  localparam logic [EL_W-1:0] DISC_REQ_T = EL_W'(DISC_REQ_US * NS_PER_US / TICK_NS);
  localparam logic [EL_W-1:0] DISC_SAMPLE_T = EL_W'(DISC_SAMPLE_US * NS_PER_US / TICK_NS);
  localparam logic [EL_W-1:0] DISC_FRAME_T = EL_W'(DISC_FRAME_US * NS_PER_US / TICK_NS);
  localparam logic [EL_W-1:0] START_HIGH_T = EL_W'(START_HIGH_US * NS_PER_US / TICK_NS);
  localparam logic [EL_W-1:0] BIT_T = EL_W'(BIT_US * NS_PER_US / TICK_NS);
  localparam logic [EL_W-1:0] LOW0_T = EL_W'(LOW0_US * NS_PER_US / TICK_NS);
  localparam logic [EL_W-1:0] LOW1_T = EL_W'(LOW1_US * NS_PER_US / TICK_NS);
  localparam logic [EL_W-1:0] RD_T = EL_W'(RD_US * NS_PER_US / TICK_NS);
  localparam logic [EL_W-1:0] MRS_T = EL_W'(MRS_US * NS_PER_US / TICK_NS);

  // Byte framing: eight data frames then the answer frame
  localparam int unsigned BYTE_W = 8;
  localparam logic [3:0] FRAME_FIRST = 4'h0;
  localparam logic [3:0] FRAME_ACK = 4'h8;
  localparam int unsigned OPCODE_W = 4;

  // User commands
  typedef enum logic [1:0] {
    CMD_RESET = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ = 2'h2,
    CMD_STOP = 2'h3
  } swh_cmd_e;

  // Controller states, Gray coded along reset, discovery, start, transfer
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RST = 3'h1,
    ST_RECOV = 3'h3,
    ST_DISC = 3'h2,
    ST_HIGH = 3'h6,
    ST_READY = 3'h7,
    ST_BIT = 3'h5
  } swh_state_e;

endpackage : swh_pkg
`default_nettype wire

/* verilog/swh_tick.sv */
/*
  Microsecond timebase: a divider of the system clock that pulses once
  per microsecond and can be restarted so a timed phase starts aligned.
  Assumes the 100 MHz system clock and a synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module swh_tick (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_clr,
  output logic o_tick
);
  import swh_pkg::*;

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic tick;
  } swh_tick_s;

  swh_tick_s tk_q;
  swh_tick_s tk_d;

  // Restart wins so a phase never sees a stale partial microsecond
  always_comb begin
    tk_d = tk_q;
    tk_d.tick = 1'b0;
    if (i_clr) begin
      tk_d.cnt = '0;
    end else if (tk_q.cnt == TICK_LAST) begin
      tk_d.cnt = '0;
      tk_d.tick = 1'b1;
    end else begin
      tk_d.cnt = tk_q.cnt + TICK_W'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tk_q <= '0;
    end else begin
      tk_q <= tk_d;
    end
  end

  assign o_tick = tk_q.tick;

endmodule : swh_tick
`default_nettype wire

/* verilog/swh_host.sv */
/*
  Bus master for a self-powered single-wire open-drain memory link: reset,
  discovery, start/stop and byte frames with the ninth answer frame.
  Assumes an external pull-up on the line and a tri-state pad driven from
  o_sio/o_sio_oe; the line level comes back on i_sio, synchronous to i_mclk.
*/
// Behaviour
// - Host opens every bit frame by pulling the line low.
// - Bytes are eight bits, shifted most significant bit first.
// - A ninth frame carries acknowledge or no-acknowledge from the receiver.
// - Data frames and answer frame follow back to back, no pause.
// - Top four address bits carry an opcode instead of the usual type code.
// - Idle device reset: hold line low at least the reset low time.
// - Possibly busy device: hold low the longer discharge time instead.
// - After reset release, wait recovery time before discovery request.
// - Discovery acknowledge must be obtained before any command.
// - Discovery request: host drives line low for the request time.
// - Host samples at discovery sample time; low means device present.
// - After discovery, line stays high the start time before first command.
// - Start and stop are both the line left high for the start time.
`timescale 1ns/1ps
`default_nettype none

module swh_host (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_cmd_valid,
  input wire swh_pkg::swh_cmd_e i_cmd,
  input wire logic [swh_pkg::BYTE_W-1:0] i_wdata,
  input wire logic i_rd_nack,
  input wire logic i_discharge,
  input wire logic i_std_speed,
  output logic o_cmd_ready,
  output logic o_done,
  output logic [swh_pkg::BYTE_W-1:0] o_rdata,
  output logic o_ack,
  output logic o_present,
  output logic o_online,
  input wire logic i_sio,
  output logic o_sio,
  output logic o_sio_oe
);
  import swh_pkg::*;

  typedef struct packed {
    swh_state_e st;
    logic [EL_W-1:0] el;
    logic clr;
    logic [3:0] bitn;
    logic rd;
    logic [BYTE_W-1:0] sh;
    logic [EL_W-1:0] lw;
    logic nack;
    logic online;
    logic present;
    logic ack_seen;
    logic [BYTE_W-1:0] rdata;
    logic done;
  } swh_host_s;

  swh_host_s q;
  swh_host_s d;
  logic tick;

  // True on the tick that completes n microseconds of the phase
  function automatic logic hit(input logic tk, input logic [EL_W-1:0] el,
                               input logic [EL_W-1:0] n);
    return tk && (el == n - EL_W'(1));
  endfunction : hit

  // Low time of a frame from its position, direction and bit value
  function automatic logic [EL_W-1:0] frame_low(input logic rd, input logic [3:0] bitn,
                                                input logic bit_v, input logic nack);
    if (bitn == FRAME_ACK) begin
      return rd ? (nack ? LOW1_T : LOW0_T) : RD_T;
    end
    return rd ? RD_T : (bit_v ? LOW1_T : LOW0_T);
  endfunction : frame_low

  // Reset low time by device state and speed
  function automatic logic [EL_W-1:0] reset_len(input logic dsch, input logic std);
    if (dsch) begin
      return DISCHARGE_T;
    end
    return std ? RESET_STD_T : RESET_HS_T;
  endfunction : reset_len

  swh_tick u_tick (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_clr(q.clr),
    .o_tick(tick)
  );

  // Next-state logic; every timed phase restarts timebase and counter
  always_comb begin
    d = q;
    d.clr = 1'b0;
    d.done = 1'b0;
    if (tick) begin
      d.el = q.el + EL_W'(1);
    end
    case (q.st)
      ST_IDLE, ST_READY: begin
        if (i_cmd_valid && i_cmd == CMD_RESET) begin
          // hold low for the reset time
          d.st = ST_RST;
          d.lw = reset_len(i_discharge, i_std_speed);
          d.online = 1'b0;
          d.present = 1'b0;
          d.el = '0;
          d.clr = 1'b1;
        end else if (i_cmd_valid && q.st == ST_READY && i_cmd == CMD_STOP) begin
          d.st = ST_HIGH;
          d.el = '0;
          d.clr = 1'b1;
        end else if (i_cmd_valid && q.st == ST_READY) begin
          // first byte carries opcode in its top bits as given
          d.rd = (i_cmd == CMD_READ);
          d.nack = i_rd_nack;
          d.sh = i_wdata;
          d.bitn = FRAME_FIRST;
          d.lw = frame_low(i_cmd == CMD_READ, FRAME_FIRST, i_wdata[BYTE_W-1], i_rd_nack);
          d.st = ST_BIT;
          d.el = '0;
          d.clr = 1'b1;
        end
      end
      ST_RST: begin
        if (hit(tick, q.el, q.lw)) begin
          d.st = ST_RECOV;
          d.el = '0;
          d.clr = 1'b1;
        end
      end
      ST_RECOV: begin
        if (hit(tick, q.el, RECOVERY_T)) begin
          d.st = ST_DISC;
          d.el = '0;
          d.clr = 1'b1;
        end
      end
      ST_DISC: begin
        // device's low hold outlasts this sample
        if (hit(tick, q.el, DISC_SAMPLE_T)) begin
          d.present = ~i_sio;
        end
        if (hit(tick, q.el, DISC_FRAME_T)) begin
          d.st = ST_HIGH;
          d.el = '0;
          d.clr = 1'b1;
        end
      end
      ST_HIGH: begin
        // high time counts only while line is really high
        if (!i_sio) begin
          d.el = '0;
        end else if (hit(tick, q.el, START_HIGH_T)) begin
          // byte and stop commands accepted only after device answered
          d.online = q.present;
          d.st = q.present ? ST_READY : ST_IDLE;
          d.done = 1'b1;
        end
      end
      ST_BIT: begin
        if (hit(tick, q.el, MRS_T)) begin
          if (!q.rd && q.bitn == FRAME_ACK) begin
            d.ack_seen = ~i_sio;
          end else if (q.rd && q.bitn != FRAME_ACK) begin
            d.sh = {q.sh[BYTE_W-2:0], i_sio};
          end
        end
        if (hit(tick, q.el, BIT_T)) begin
          if (q.bitn == FRAME_ACK) begin
            d.st = ST_READY;
            d.done = 1'b1;
            if (q.rd) begin
              d.rdata = q.sh;
            end
          end else begin
            d.bitn = q.bitn + 4'h1;
            if (!q.rd) begin
              // next bit down toward the least significant
              d.sh = {q.sh[BYTE_W-2:0], 1'b0};
            end
            d.lw = frame_low(q.rd, q.bitn + 4'h1, q.sh[BYTE_W-2], q.nack);
            d.el = '0;
            d.clr = 1'b1;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Line drive: only ever pulled low, released lets the pull-up win
  // each frame opens low; discovery request low
  assign o_sio = 1'b0;
  assign o_sio_oe = (q.st == ST_RST) || (q.st == ST_DISC && q.el < DISC_REQ_T) ||
                    (q.st == ST_BIT && q.el < q.lw);

  // User-side status
  assign o_cmd_ready = (q.st == ST_IDLE) || (q.st == ST_READY);
  assign o_done = q.done;
  assign o_rdata = q.rdata;
  assign o_ack = q.ack_seen;
  assign o_present = q.present;
  assign o_online = q.online;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  sequence s_frame_open;
    (q.st == ST_BIT) && q.clr;
  endsequence

  sequence s_disc_open;
    $rose(q.st == ST_DISC);
  endsequence

  a_frame_low_start: assert property (s_frame_open |-> o_sio_oe)
    else $error("frame did not open low");

  a_msb_first_order: assert property (s_frame_open ##0 (!q.rd && q.bitn != FRAME_ACK)
    |-> q.lw == (q.sh[BYTE_W-1] ? LOW1_T : LOW0_T))
    else $error("write frame not driven from top bit");

  a_ack_ninth_frame: assert property (s_frame_open ##0 (q.bitn == FRAME_ACK)
    |-> q.lw == (q.rd ? (q.nack ? LOW1_T : LOW0_T) : RD_T))
    else $error("answer frame of wrong kind");

  a_no_frame_gap: assert property ((q.st == ST_BIT && q.bitn != FRAME_ACK &&
    hit(tick, q.el, BIT_T)) |=> s_frame_open)
    else $error("gap inside a byte");

  a_reset_hold_len: assert property ($rose(q.st == ST_RECOV)
    |-> $past(q.el) == $past(q.lw) - EL_W'(1) && $past(tick))
    else $error("reset low too short");

  a_reset_drive_low: assert property (q.st == ST_RST |-> o_sio_oe)
    else $error("line released during reset");

  a_recovery_wait: assert property ($rose(q.st == ST_DISC)
    |-> $past(q.el) == RECOVERY_T - EL_W'(1))
    else $error("discovery requested early");

  a_online_before_cmd: assert property (q.st == ST_BIT |-> q.online)
    else $error("command before discovery");

  a_disc_request_low: assert property (s_disc_open |-> o_sio_oe [*2])
    else $error("discovery request not driven");

  a_disc_sample_point: assert property ((q.st == ST_DISC &&
    hit(tick, q.el, DISC_SAMPLE_T)) |=> q.present == !$past(i_sio))
    else $error("presence not taken at sample point");

  a_start_high_time: assert property ($rose(q.st == ST_READY) && $past(q.st == ST_HIGH)
    |-> $past(q.el) == START_HIGH_T - EL_W'(1) && $past(i_sio) && !$past(o_sio_oe))
    else $error("start high time not kept");

  // Reset phase entry, used to check the length picked for it
  sequence s_reset_open;
    $rose(q.st == ST_RST);
  endsequence

  a_std_reset_len: assert property (s_reset_open
    ##0 (!$past(i_discharge) && $past(i_std_speed)) |-> q.lw == RESET_STD_T)
    else $error("standard speed reset too short");

  a_discharge_len: assert property (s_reset_open ##0 $past(i_discharge)
    |-> q.lw == DISCHARGE_T)
    else $error("busy reset not a full discharge");

  a_line_free_idle: assert property ((q.st == ST_IDLE || q.st == ST_READY ||
    q.st == ST_RECOV || q.st == ST_HIGH) |-> !o_sio_oe)
    else $error("line driven outside a low phase");

  a_read_msb_shift: assert property ((q.st == ST_BIT && q.rd && q.bitn != FRAME_ACK &&
    hit(tick, q.el, MRS_T)) |=> q.sh[0] == $past(i_sio))
    else $error("read bit not shifted in at the bottom");

  a_write_ack_taken: assert property ((q.st == ST_BIT && !q.rd && q.bitn == FRAME_ACK &&
    hit(tick, q.el, MRS_T)) |=> q.ack_seen == !$past(i_sio))
    else $error("device answer not taken");

endmodule : swh_host
`default_nettype wire

/* verification/swh_dev_model.sv */
/*
  Behavioural model of the single-wire memory at the far end of the line.
  Assumes an open-drain line with pull-up, resolved by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module swh_dev_model #(
  parameter int unsigned SAMPLE_NS = 4000,
  parameter int unsigned HOLD_NS = 4000,
  parameter int unsigned DISC_ACK_NS = 4000
) (
  input wire logic i_line,
  input wire logic i_rd_mode,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_ack_en,
  input wire logic i_busy,
  output logic o_pull,
  output logic [7:0] o_rx_byte,
  output logic o_host_nack,
  output logic [7:0] o_reset_cnt
);
  import swh_pkg::*;
  realtime t_fall = 0;
  logic disc_q = 1'b1;
  logic hs_q = 1'b1;
  logic [7:0] addr_q = 8'h00;
  logic out_frame;
  logic obit;
  int nbit = 0;

  initial begin
    o_pull = 1'b0;
    o_rx_byte = 8'h00;
    o_host_nack = 1'b0;
    o_reset_cnt = 8'h00;
  end

  // Long low resets; busy needs a discharge
  always @(posedge i_line) begin
    if ($realtime - t_fall >= (i_busy ? DISCHARGE_US : (hs_q ? RESET_HS_US : RESET_STD_US))
        * 1000.0) begin
      hs_q = 1'b1;
      addr_q = 8'h00;
      disc_q = 1'b1;
      nbit = 0;
      o_reset_cnt = o_reset_cnt + 8'h01;
    end
  end

  always @(negedge i_line) begin
    t_fall = $realtime;
    out_frame = i_rd_mode ? (nbit < 8) : (nbit == 8);
    obit = (nbit == 8) ? !i_ack_en : i_tx_byte[7 - nbit];
    if (i_busy) begin
      // Busy device neither answers nor samples
      o_pull = 1'b0;
    end else if (disc_q) begin
      disc_q = 1'b0;
      o_pull = 1'b1;
      #(DISC_ACK_NS);
      o_pull = 1'b0;
    end else begin
      if (out_frame) begin
        if (!obit) begin
          o_pull = 1'b1;
          #(HOLD_NS);
          o_pull = 1'b0;
        end
      end else begin
        #(SAMPLE_NS);
        if (nbit == 8) o_host_nack = i_line;
        else o_rx_byte = {o_rx_byte[6:0], i_line};
      end
      nbit = (nbit == 8) ? 0 : nbit + 1;
    end
  end
endmodule : swh_dev_model

`default_nettype wire

/* verification/swh_host_tb.sv */
/*
  Self-checking bench for the single-wire host controller.
  Assumes the device model on the same line and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module swh_host_tb;
  import swh_pkg::*;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_cmd_valid = 1'b0;
  swh_cmd_e i_cmd = CMD_RESET;
  logic [7:0] i_wdata = 8'h00;
  logic i_rd_nack = 1'b0;
  logic i_discharge = 1'b0;
  logic i_std_speed = 1'b0;
  logic o_cmd_ready, o_done, o_ack, o_present, o_online, o_sio, o_sio_oe;
  logic [7:0] o_rdata, rx_byte, reset_cnt;
  logic dev_pull, host_nack;
  logic rd_mode = 1'b0;
  logic ack_en = 1'b1;
  logic [7:0] tx_byte = 8'h00;
  logic dev_busy = 1'b0;
  wire logic sio_line = (o_sio_oe ? o_sio : 1'b1) & ~dev_pull;
  int miscompares = 0;
  int n_tests = 0;
  int ncyc;

  always #5 i_mclk = ~i_mclk;

  swh_host dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_wdata(i_wdata), .i_rd_nack(i_rd_nack), .i_discharge(i_discharge),
    .i_std_speed(i_std_speed), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
    .o_rdata(o_rdata), .o_ack(o_ack), .o_present(o_present), .o_online(o_online),
    .i_sio(sio_line), .o_sio(o_sio), .o_sio_oe(o_sio_oe));

  swh_dev_model dev (.i_line(sio_line), .i_rd_mode(rd_mode), .i_tx_byte(tx_byte),
    .i_ack_en(ack_en), .i_busy(dev_busy), .o_pull(dev_pull), .o_rx_byte(rx_byte),
    .o_host_nack(host_nack), .o_reset_cnt(reset_cnt));

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_len(input logic [EL_W-1:0] got, input logic [EL_W-1:0] exp,
                         input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : chk_len

  // Mid-run reset; the first two edges after release must show idle
  task automatic mid_reset();
    i_srst = 1'b1;
    repeat (2) @(posedge i_mclk);
    #1 i_srst = 1'b0;
    repeat (2) begin
      @(posedge i_mclk);
      #1;
      chk({6'h0, o_sio_oe, o_online}, 8'h00, "state after mid-run reset");
      chk({7'h0, o_cmd_ready}, 8'h01, "ready after mid-run reset");
    end
  endtask : mid_reset

  // Reset length by speed and busy state, each cut short by a mid-run reset
  task automatic t_speed();
    i_std_speed = 1'b1;
    i_cmd = CMD_RESET;
    i_cmd_valid = 1'b1;
    @(posedge i_mclk);
    #1 i_cmd_valid = 1'b0;
    chk_len(dut.q.lw, RESET_STD_T, "standard speed reset length");
    chk({7'h0, o_sio_oe}, 8'h01, "reset drives line");
    chk({7'h0, o_sio}, 8'h00, "line only pulled low");
    mid_reset();
    repeat (500) @(posedge i_mclk);
    #1 i_discharge = 1'b1;
    dev_busy = 1'b1;
    i_cmd_valid = 1'b1;
    @(posedge i_mclk);
    #1 i_cmd_valid = 1'b0;
    chk_len(dut.q.lw, DISCHARGE_T, "busy reset length");
    mid_reset();
    chk({7'h0, sio_line}, 8'h01, "busy device left line alone");
    i_discharge = 1'b0;
    i_std_speed = 1'b0;
    dev_busy = 1'b0;
  endtask : t_speed

  // Present a command, hold it until taken, then wait for done
  task automatic run(input swh_cmd_e c, input logic [7:0] d, input int lim);
    i_cmd = c;
    i_wdata = d;
    i_cmd_valid = 1'b1;
    while (o_cmd_ready !== 1'b1) begin
      @(posedge i_mclk);
      #1;
    end
    @(posedge i_mclk);
    #1 i_cmd_valid = 1'b0;
    ncyc = 0;
    while (o_done !== 1'b1 && ncyc < lim) begin
      @(posedge i_mclk);
      #1;
      ncyc++;
    end
    chk({7'h0, o_done}, 8'h01, "command completion");
  endtask : run

  // Byte command before discovery must leave the line alone
  task automatic t_refuse();
    logic seen;
    seen = 1'b0;
    i_cmd = CMD_WRITE;
    i_cmd_valid = 1'b1;
    @(posedge i_mclk);
    #1 i_cmd_valid = 1'b0;
    repeat (300) begin
      @(posedge i_mclk);
      #1;
      if (o_done !== 1'b0 || o_sio_oe !== 1'b0) seen = 1'b1;
    end
    chk({7'h0, seen}, 8'h00, "early write acted");
    chk({7'h0, o_cmd_ready}, 8'h01, "ready after refusal");
  endtask : t_refuse

  task automatic t_reset();
    run(CMD_RESET, 8'h00, 40000);
    chk(reset_cnt, 8'h01, "device reset count");
    chk({7'h0, o_present}, 8'h01, "discovery present");
    chk({7'h0, o_online}, 8'h01, "online");
    chk({7'h0, ncyc >= (RESET_HS_T + RECOVERY_T + START_HIGH_T) * TICK_CYC},
      8'h01, "reset length");
  endtask : t_reset

  task automatic t_write(input logic [7:0] d, input logic ack);
    rd_mode = 1'b0;
    ack_en = ack;
    run(CMD_WRITE, d, 11500);
    chk(rx_byte, d, "byte at device");
    chk({7'h0, o_ack}, {7'h0, ack}, "write answer");
    chk({7'h0, ncyc >= 9 * BIT_T * TICK_CYC && ncyc <= 9 * BIT_T * TICK_CYC + 100},
      8'h01, "byte length");
  endtask : t_write

  task automatic t_read(input logic [7:0] d, input logic nack);
    rd_mode = 1'b1;
    tx_byte = d;
    i_rd_nack = nack;
    run(CMD_READ, 8'h00, 11500);
    chk(o_rdata, d, "read byte");
    chk({7'h0, host_nack}, {7'h0, nack}, "host answer");
  endtask : t_read

  task automatic t_stop();
    run(CMD_STOP, 8'h00, 16000);
    chk({7'h0, ncyc >= START_HIGH_T * TICK_CYC}, 8'h01, "stop high time");
    chk({7'h0, o_cmd_ready}, 8'h01, "ready after stop");
  endtask : t_stop

  // Main sequence
  initial begin
    repeat (5) @(posedge i_mclk);
    #1 i_srst = 1'b0;
    chk({7'h0, o_online}, 8'h00, "offline after reset");
    t_refuse();
    t_speed();
    t_reset();
    t_write(8'hd6, 1'b1);
    t_write(8'h29, 1'b0);
    t_read(8'hb4, 1'b1);
    t_read(8'h4b, 1'b0);
    t_stop();
    conclude();
  end

  // Watchdog, past the expected run of about 93,000 cycles
  initial begin
    #980000;
    miscompares++;
    conclude();
  end
endmodule : swh_host_tb

`default_nettype wire
